// ### logic/obi_bus_parity_checksum.sv
// Top of the bus parity and checksum block for the fetch and data ports.
// Assumes fabric inputs are asynchronous to mclk and pass two flops first.
`timescale 1ns/1ps
`include "obipc_regs.svh"

module obi_bus_parity_checksum (
	// Clock and reset
	input  wire logic                      mclk,
	input  wire logic                      arst_n,
	input  wire logic                      clkEn,
	// Integrity enables
	input  wire logic                      intgGlobal,
	input  wire logic                      iRegionIntg,
	input  wire logic                      dRegionIntg,
	// Fetch request from core
	input  wire logic                      iReq,
	input  wire logic [`OBIPC_AW-1:0]      iAddr,
	input  wire logic [2:0]                iProt,
	input  wire logic [1:0]                iMemType,
	input  wire logic                      iDbg,
	input  wire logic                      iExecute,
	// Fetch response from fabric
	input  wire logic                      iGnt,
	input  wire logic                      iGntPar,
	input  wire logic                      iRvalid,
	input  wire logic                      iRvalidPar,
	input  wire logic [`OBIPC_DW-1:0]      iRdata,
	input  wire logic                      iErr,
	input  wire logic [`OBIPC_RCHK_W-1:0]  iRchk,
	// Data request from core
	input  wire logic                      dReq,
	input  wire logic [`OBIPC_AW-1:0]      dAddr,
	input  wire logic [2:0]                dProt,
	input  wire logic [1:0]                dMemType,
	input  wire logic [3:0]                dBe,
	input  wire logic                      dWe,
	input  wire logic                      dDbg,
	input  wire logic [`OBIPC_DW-1:0]      dWdata,
	input  wire logic                      dRspIsRead,
	// Data response from fabric
	input  wire logic                      dGnt,
	input  wire logic                      dGntPar,
	input  wire logic                      dRvalid,
	input  wire logic                      dRvalidPar,
	input  wire logic [`OBIPC_DW-1:0]      dRdata,
	input  wire logic                      dErr,
	input  wire logic [`OBIPC_RCHK_W-1:0]  dRchk,
	// Request integrity outputs
	output logic                           iReqPar,
	output obipc_pkg::obipc_achk_t         iAchk,
	output logic                           dReqPar,
	output obipc_pkg::obipc_achk_t         dAchk,
	// Alerts, faults and NMIs
	output logic                           alertMajor,
	output logic                           instrFault,
	output logic                           loadNmi,
	output logic                           storeNmi,
	output obipc_pkg::obipc_cause_t        cause
);
	import obipc_pkg::*;

	typedef struct packed {
		logic [1:0]   iGntS;
		logic [1:0]   iGntParS;
		logic [1:0]   iRvS;
		logic [1:0]   iRvParS;
		logic [1:0]   dGntS;
		logic [1:0]   dGntParS;
		logic [1:0]   dRvS;
		logic [1:0]   dRvParS;
		logic [`OBIPC_DW-1:0] iRdS0, iRdS1, dRdS0, dRdS1;
		logic [1:0]   iErrS, dErrS;
		logic [`OBIPC_RCHK_W-1:0] iRchkS0, iRchkS1, dRchkS0, dRchkS1;
		logic         iFetchBad;
		logic         iReqPar;
		obipc_achk_t  iAchk;
		logic         dReqPar;
		obipc_achk_t  dAchk;
		logic         alertMajor;
		logic         instrFault;
		logic         loadNmi;
		logic         storeNmi;
		obipc_cause_t cause;
	} obipc_state_t;

	obipc_state_t st_r;
	obipc_state_t st_nxt;

	// Parity stages reset to the idle fabric level (low strobe, high parity) so that
	// no false grant or valid parity error, and no alert, follows reset.
	localparam obipc_state_t ST_RST = '{
		iGntParS: `OBIPC_PAR_IDLE,
		iRvParS:  `OBIPC_PAR_IDLE,
		dGntParS: `OBIPC_PAR_IDLE,
		dRvParS:  `OBIPC_PAR_IDLE,
		iReqPar:  `OBIPC_REQPAR_IDLE,
		dReqPar:  `OBIPC_REQPAR_IDLE,
		default:  '0
	};

	obipc_chk_if iRes ();
	obipc_chk_if dRes ();

	logic iAnyErr;
	logic dAnyErr;
	logic iRspErr;

	////////////////////////////////////////////////////////////////////////////////
	// Per-port checkers: response inputs from the second synchroniser stage, request inputs straight from the core.

	obipc_port_chk #(.IS_INSTR(1'b1)) u_ichk (
		.req       (iReq),
		.addr      (iAddr),
		.prot      (iProt),
		.memType   (iMemType),
		.be        (`OBIPC_IFETCH_BE),
		.we        (1'b0),
		.dbg       (iDbg),
		.wdata     (`OBIPC_WD_ZERO),
		.gnt       (st_r.iGntS[1]),
		.gntPar    (st_r.iGntParS[1]),
		.rvalid    (st_r.iRvS[1]),
		.rvalidPar (st_r.iRvParS[1]),
		.rdata     (st_r.iRdS1),
		.err       (st_r.iErrS[1]),
		.rchk      (st_r.iRchkS1),
		.rdXfer    (1'b1),
		.chkEn     (intgGlobal && iRegionIntg),
		.res       (iRes.chk)
	);

	obipc_port_chk #(.IS_INSTR(1'b0)) u_dchk (
		.req       (dReq),
		.addr      (dAddr),
		.prot      (dProt),
		.memType   (dMemType),
		.be        (dBe),
		.we        (dWe),
		.dbg       (dDbg),
		.wdata     (dWdata),
		.gnt       (st_r.dGntS[1]),
		.gntPar    (st_r.dGntParS[1]),
		.rvalid    (st_r.dRvS[1]),
		.rvalidPar (st_r.dRvParS[1]),
		.rdata     (st_r.dRdS1),
		.err       (st_r.dErrS[1]),
		.rchk      (st_r.dRchkS1),
		.rdXfer    (dRspIsRead),
		.chkEn     (intgGlobal && dRegionIntg),
		.res       (dRes.chk)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state.

	assign iRspErr = iRes.rchkErr || iRes.rvalidErr;
	assign iAnyErr = iRes.gntErr || iRspErr;
	assign dAnyErr = dRes.gntErr || dRes.rvalidErr || dRes.rchkErr;

	always_comb begin
		st_nxt = st_r;
		st_nxt.iGntS    = {st_r.iGntS[0], iGnt};
		st_nxt.iGntParS = {st_r.iGntParS[0], iGntPar};
		st_nxt.iRvS     = {st_r.iRvS[0], iRvalid};
		st_nxt.iRvParS  = {st_r.iRvParS[0], iRvalidPar};
		st_nxt.dGntS    = {st_r.dGntS[0], dGnt};
		st_nxt.dGntParS = {st_r.dGntParS[0], dGntPar};
		st_nxt.dRvS     = {st_r.dRvS[0], dRvalid};
		st_nxt.dRvParS  = {st_r.dRvParS[0], dRvalidPar};
		st_nxt.iRdS0    = iRdata;
		st_nxt.iRdS1    = st_r.iRdS0;
		st_nxt.dRdS0    = dRdata;
		st_nxt.dRdS1    = st_r.dRdS0;
		st_nxt.iErrS    = {st_r.iErrS[0], iErr};
		st_nxt.dErrS    = {st_r.dErrS[0], dErr};
		st_nxt.iRchkS0  = iRchk;
		st_nxt.iRchkS1  = st_r.iRchkS0;
		st_nxt.dRchkS0  = dRchk;
		st_nxt.dRchkS1  = st_r.dRchkS0;
		st_nxt.iReqPar  = iRes.reqPar;
		st_nxt.iAchk    = iRes.achk;
		st_nxt.dReqPar  = dRes.reqPar;
		st_nxt.dAchk    = dRes.achk;
		st_nxt.instrFault = 1'b0;
		st_nxt.loadNmi    = 1'b0;
		st_nxt.storeNmi   = 1'b0;
		st_nxt.alertMajor = iAnyErr || dAnyErr;
		if (iExecute && st_r.iFetchBad) begin
			st_nxt.instrFault = 1'b1;
			st_nxt.alertMajor = 1'b1;
			st_nxt.cause      = `OBIPC_CAUSE_INSTR;
			st_nxt.iFetchBad  = 1'b0;
		end
		// A bad fetch response is remembered until that word is executed; a new
		// good response replaces it, so only the executed word can fault.
		// The store follows the clear so that a response landing as the old word
		// executes is kept rather than wiped.
		if (st_r.iRvS[1]) begin
			st_nxt.iFetchBad = iRspErr;
		end
		// A data NMI in the same cycle as a fetch fault takes the cause code;
		// the fetch fault is still flagged on its own output.
		if (st_r.dRvS[1] && (dRes.rchkErr || dRes.rvalidErr)) begin
			if (dRspIsRead) begin
				st_nxt.loadNmi = 1'b1;
				st_nxt.cause   = `OBIPC_CAUSE_LOAD;
			end else begin
				st_nxt.storeNmi = 1'b1;
				st_nxt.cause    = `OBIPC_CAUSE_STORE;
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= ST_RST;
		end else if (clkEn) begin
			st_r <= st_nxt;
		end
	end

	assign iReqPar    = st_r.iReqPar;
	assign iAchk      = st_r.iAchk;
	assign dReqPar    = st_r.dReqPar;
	assign dAchk      = st_r.dAchk;
	assign alertMajor = st_r.alertMajor;
	assign instrFault = st_r.instrFault;
	assign loadNmi    = st_r.loadNmi;
	assign storeNmi   = st_r.storeNmi;
	assign cause      = st_r.cause;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n || !clkEn);

	a_req_par_odd: assert property (1'b1 ##1 $past(clkEn) |-> (dReqPar != $past(dReq)))
		else $error("data request parity not odd");
	a_alert_on_gnt: assert property (dRes.gntErr |=> alertMajor)
		else $error("grant parity error without alert");
	a_alert_cause: assert property ($rose(alertMajor) |-> $past(iAnyErr || dAnyErr || (iExecute && st_r.iFetchBad)))
		else $error("alert without cause");
	a_chk_gated: assert property (st_r.dRvS[1] && !(intgGlobal && dRegionIntg) &&
		!dRes.rvalidErr |=> !loadNmi && !storeNmi)
		else $error("checksum checked while disabled");
	a_load_cause: assert property (loadNmi |-> cause == `OBIPC_CAUSE_LOAD && alertMajor)
		else $error("load NMI wrong cause");
	a_store_cause: assert property (storeNmi |-> cause == `OBIPC_CAUSE_STORE && alertMajor)
		else $error("store NMI wrong cause");
	a_fault_cause: assert property (instrFault |-> cause == `OBIPC_CAUSE_INSTR && alertMajor)
		else $error("fetch fault wrong cause");
	a_fetch_exec: assert property (instrFault |-> $past(iExecute))
		else $error("fetch fault without execution");
	a_wd_bits: assert property ($past(clkEn) |-> dAchk[`OBIPC_ACHK_WD] == ^$past(dWdata[7:0]))
		else $error("write data checksum lane 0 wrong");
	a_ireq_par_odd: assert property ($past(clkEn) |-> (iReqPar != $past(iReq)))
		else $error("fetch request parity not odd");
	a_ifetch_be: assert property ($past(clkEn) && $past(arst_n) |-> iAchk[`OBIPC_ACHK_BE])
		else $error("fetch byte enable checksum wrong");
	a_ifetch_wd: assert property (iAchk[`OBIPC_ACHK_WD +: `OBIPC_LANES] == '0)
		else $error("fetch write data checksum not zero");
	a_atop_zero: assert property (dAchk[`OBIPC_ACHK_ATOP] == 1'b0)
		else $error("atomic checksum bit set");
	a_rv_nmi: assert property (st_r.dRvS[1] && dRes.rvalidErr |=> loadNmi || storeNmi)
		else $error("valid parity error without NMI");
	a_fetch_keep: assert property (st_r.iRvS[1] && iRspErr |=> st_r.iFetchBad)
		else $error("bad fetch response not stored");
	a_write_lanes: assert property (st_r.dRvS[1] && !dRspIsRead && !dRes.rvalidErr &&
		(st_r.dRchkS1[`OBIPC_RCHK_ERR] == st_r.dErrS[1]) |=> !storeNmi)
		else $error("write response lanes checked");

	////////////////////////////////////////////////////////////////////////////////
	// Scenario covers.

	c_load_nmi:  cover property (loadNmi);
	c_store_nmi: cover property (storeNmi);
	c_fetch:     cover property (instrFault);
	c_alert:     cover property (alertMajor ##1 !alertMajor);
	c_gnt_err:   cover property (dRes.gntErr ##1 alertMajor);
endmodule : obi_bus_parity_checksum

// ### logic/obipc_chk_if.sv
// Carries one port's checker results between the top and the per-port checker.
// Assumes both ends run on mclk.
`timescale 1ns/1ps
interface obipc_chk_if;
	import obipc_pkg::*;
	obipc_achk_t achk;
	logic        reqPar;
	logic        gntErr;
	logic        rvalidErr;
	logic        rchkErr;
	modport chk (output achk, reqPar, gntErr, rvalidErr, rchkErr);
	modport top (input achk, reqPar, gntErr, rvalidErr, rchkErr);
endinterface : obipc_chk_if

// ### logic/obipc_pkg.sv
// Types shared by the bus parity and checksum block.
// Assumes obipc_regs.svh is on the include path.
`include "obipc_regs.svh"
package obipc_pkg;
	typedef logic [`OBIPC_CAUSE_W-1:0] obipc_cause_t;
	typedef logic [`OBIPC_ACHK_W-1:0]  obipc_achk_t;
	typedef logic [`OBIPC_RCHK_W-1:0]  obipc_rchk_t;
endpackage : obipc_pkg

// ### logic/obipc_port_chk.sv
// Combinational parity/checksum generator and checker for one bus port.
// Assumes synchronised inputs; results are registered by the parent.
`timescale 1ns/1ps
`include "obipc_regs.svh"
module obipc_port_chk #(
	parameter bit IS_INSTR = 1'b0
) (
	// Request side
	input  wire logic                 req,
	input  wire logic [`OBIPC_AW-1:0] addr,
	input  wire logic [2:0]           prot,
	input  wire logic [1:0]           memType,
	input  wire logic [3:0]           be,
	input  wire logic                 we,
	input  wire logic                 dbg,
	input  wire logic [`OBIPC_DW-1:0] wdata,
	// Response side
	input  wire logic                 gnt,
	input  wire logic                 gntPar,
	input  wire logic                 rvalid,
	input  wire logic                 rvalidPar,
	input  wire logic [`OBIPC_DW-1:0] rdata,
	input  wire logic                 err,
	input  wire logic [`OBIPC_RCHK_W-1:0] rchk,
	input  wire logic                 rdXfer,
	input  wire logic                 chkEn,
	// Results
	obipc_chk_if.chk                  res
);
	import obipc_pkg::*;

	logic [3:0]           beEff;
	logic                 weEff;
	logic [`OBIPC_DW-1:0] wdEff;
	logic [`OBIPC_RCHK_W-1:0] rchkExp;

	always_comb begin
		// Fetch port has fixed word reads with no write data.
		beEff = IS_INSTR ? `OBIPC_IFETCH_BE : be;
		weEff = IS_INSTR ? 1'b0 : we;
		wdEff = IS_INSTR ? `OBIPC_WD_ZERO : wdata;
		res.reqPar = ~req;
		for (int i = 0; i < `OBIPC_LANES; i++) begin
			res.achk[i] = ^addr[8*i +: 8];
			res.achk[`OBIPC_ACHK_WD+i] = ^wdEff[8*i +: 8];
			rchkExp[i] = ^rdata[8*i +: 8];
		end
		res.achk[`OBIPC_ACHK_PROT] = ~^{prot, memType};
		res.achk[`OBIPC_ACHK_BE]   = ~^{beEff, weEff};
		res.achk[`OBIPC_ACHK_DBG]  = ~dbg;
		res.achk[`OBIPC_ACHK_ATOP] = ^`OBIPC_ATOP_ZERO;
		rchkExp[`OBIPC_RCHK_ERR]   = err;
		// Grant and valid parity are always checked.
		res.gntErr    = gntPar == gnt;
		res.rvalidErr = rvalidPar == rvalid;
		res.rchkErr   = rvalid && chkEn &&
			((rchk[`OBIPC_RCHK_ERR] != rchkExp[`OBIPC_RCHK_ERR]) ||
			 (rdXfer && (rchk[3:0] != rchkExp[3:0])));
	end
endmodule : obipc_port_chk

// ### logic/obipc_regs.svh
// Constants for the bus parity and checksum block: widths, bit positions, cause codes.
// Assumes inclusion by bare name; definitions only.
`ifndef OBIPC_REGS_SVH
`define OBIPC_REGS_SVH
`define OBIPC_AW          32
`define OBIPC_DW          32
`define OBIPC_ACHK_W      12
`define OBIPC_RCHK_W      5
`define OBIPC_ACHK_PROT   4
`define OBIPC_ACHK_BE     5
`define OBIPC_ACHK_DBG    6
`define OBIPC_ACHK_ATOP   7
`define OBIPC_ACHK_WD     8
`define OBIPC_RCHK_ERR    4
`define OBIPC_LANES       4
`define OBIPC_IFETCH_BE   4'hF
`define OBIPC_ATOP_ZERO   6'h00
`define OBIPC_WD_ZERO     32'h0000_0000
`define OBIPC_CAUSE_W     11
`define OBIPC_CAUSE_INSTR 11'h019
`define OBIPC_CAUSE_LOAD  11'h402
`define OBIPC_CAUSE_STORE 11'h403
`define OBIPC_PAR_IDLE    2'h3
`define OBIPC_REQPAR_IDLE 1'h1
`endif

// ### tb/obi_bus_parity_checksum_tb.sv
// Self-checking bench for the bus parity and checksum block.
// Assumes obipc_regs.svh on the include path; fabric pins reach the checkers in two flops.
`timescale 1ns/1ps
`include "obipc_regs.svh"
module obi_bus_parity_checksum_tb;
	import obipc_pkg::*;
	logic mclk = 0, arst_n = 0, clkEn = 1, intgGlobal = 1, iRegionIntg = 1, dRegionIntg = 1;
	logic iReq = 0, iDbg = 0, iExecute = 0, dReq = 0, dWe = 0, dDbg = 0, dRspIsRead = 0;
	logic [31:0] iAddr = '0, dAddr = '0, dWdata = '0, iRdata = '0, dRdata = '0;
	logic [2:0] iProt = '0, dProt = '0;
	logic [1:0] iMemType = '0, dMemType = '0;
	logic [3:0] dBe = '0;
	logic iGnt = 0, iRvalid = 0, iErr = 0, dGnt = 0, dRvalid = 0, dErr = 0;
	logic iBadGnt = 0, iBadRv = 0, dBadGnt = 0, dBadRv = 0;
	logic [4:0] iBadRchk = '0, dBadRchk = '0, iRchk, dRchk;
	logic iGntPar, iRvalidPar, dGntPar, dRvalidPar, iReqPar, dReqPar;
	logic alertMajor, instrFault, loadNmi, storeNmi;
	obipc_achk_t iAchk, dAchk;
	obipc_cause_t cause;
	int nErrors = 0, comparisons = 0, cycles = 0, nAlert, nLoad, nStore, nFault;

	always #20 mclk = ~mclk;

	obi_bus_parity_checksum i_dut (.*);
	obipc_fabric_model i_ifab (.gnt(iGnt), .rvalid(iRvalid), .rdata(iRdata), .err(iErr),
		.badGnt(iBadGnt), .badRv(iBadRv), .badRchk(iBadRchk), .gntPar(iGntPar),
		.rvalidPar(iRvalidPar), .rchk(iRchk));
	obipc_fabric_model i_dfab (.gnt(dGnt), .rvalid(dRvalid), .rdata(dRdata), .err(dErr),
		.badGnt(dBadGnt), .badRv(dBadRv), .badRchk(dBadRchk), .gntPar(dGntPar),
		.rvalidPar(dRvalidPar), .rchk(dRchk));

	////////////////////////////////////////////////////////////////////////////////
	// Pulse counting and run control

	always @(posedge mclk) begin
		cycles++;
		nAlert += (alertMajor === 1'b1);
		nLoad  += (loadNmi === 1'b1);
		nStore += (storeNmi === 1'b1);
		nFault += (instrFault === 1'b1);
		// Whole run needs some 84 cycles; the ceiling leaves ample margin.
		if (cycles == 2000) begin
			nErrors++;
			stopTest();
		end
	end

	task automatic stopTest();
		$display("comparisons %0d mismatches %0d", comparisons, nErrors);
		if (nErrors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : stopTest

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			nErrors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	function automatic obipc_achk_t achkOf(input logic [31:0] a, input logic [2:0] p,
			input logic [1:0] m, input logic [3:0] b, input logic w, input logic g,
			input logic [31:0] wd);
		obipc_achk_t r;
		for (int i = 0; i < 4; i++) begin
			r[i]     = ^a[8*i +: 8];
			r[8 + i] = ^wd[8*i +: 8];
		end
		r[4] = ~^{p, m};
		r[5] = ~^{b, w};
		r[6] = ~g;
		r[7] = 1'b0;
		return r;
	endfunction : achkOf

	// One-cycle fabric event on one port, then a window long enough for the alert.
	task automatic fabPulse(input bit onData, input bit gntOn, input bit rvOn, input bit gBad,
			input bit rBad, input logic [4:0] cBad);
		@(negedge mclk);
		{nAlert, nLoad, nStore, nFault} = '0;
		@(posedge mclk);
		if (onData) {dGnt, dRvalid, dBadGnt, dBadRv, dBadRchk} <= {gntOn, rvOn, gBad, rBad, cBad};
		else {iGnt, iRvalid, iBadGnt, iBadRv, iBadRchk} <= {gntOn, rvOn, gBad, rBad, cBad};
		@(posedge mclk);
		{dGnt, dRvalid, dBadGnt, dBadRv, dBadRchk} <= '0;
		{iGnt, iRvalid, iBadGnt, iBadRv, iBadRchk} <= '0;
		// Released data lines must not keep showing the last word.
		dRdata <= ~dRdata;
		iRdata <= ~iRdata;
		repeat (6) @(posedge mclk);
		// Judge off the edge, once the pulse counters have settled.
		@(negedge mclk);
	endtask : fabPulse

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios

	task automatic tRequest();
		@(posedge mclk);
		{iReq, iAddr, iProt, iMemType, iDbg} <= {1'b1, 32'h8000_01FF, 3'h5, 2'h2, 1'b1};
		{dReq, dAddr, dProt, dMemType} <= {1'b0, 32'hFFFF_0000, 3'h0, 2'h3};
		{dBe, dWe, dDbg, dWdata} <= {4'h1, 1'b0, 1'b0, 32'h0100_0F07};
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		chk(iReqPar, 32'h0);
		chk(dReqPar, 32'h1);
		chk(iAchk, achkOf(iAddr, iProt, iMemType, 4'hF, 1'b0, iDbg, '0));
		chk(dAchk, achkOf(dAddr, dProt, dMemType, dBe, dWe, dDbg, dWdata));
		$display("test request done");
	endtask : tRequest

	// Clock enable low must freeze the registered parity even as the request moves.
	task automatic tFreeze();
		@(posedge mclk);
		{clkEn, dReq} <= 2'b01;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		chk(dReqPar, 32'h1);
		@(posedge mclk);
		clkEn <= 1'b1;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		chk(dReqPar, 32'h0);
		@(posedge mclk);
		dReq <= 1'b0;
		$display("test freeze done");
	endtask : tFreeze

	task automatic tData();
		dRspIsRead <= 1'b1;
		fabPulse(1, 0, 1, 0, 0, 5'h08);
		chk(nAlert, 1);
		chk(nLoad, 1);
		chk(cause, `OBIPC_CAUSE_LOAD);
		dRspIsRead <= 1'b0;
		fabPulse(1, 0, 1, 0, 1, 5'h00);
		chk(nStore, 1);
		chk(cause, `OBIPC_CAUSE_STORE);
		fabPulse(1, 0, 1, 0, 0, 5'h01);
		chk(nAlert, 0);
		$display("test data done");
	endtask : tData

	task automatic tGate();
		dRspIsRead <= 1'b1;
		intgGlobal <= 1'b0;
		fabPulse(1, 0, 1, 0, 0, 5'h10);
		chk(nAlert, 0);
		intgGlobal  <= 1'b1;
		dRegionIntg <= 1'b0;
		fabPulse(1, 0, 1, 0, 0, 5'h02);
		chk(nAlert, 0);
		intgGlobal <= 1'b0;
		fabPulse(1, 1, 0, 1, 0, 5'h00);
		chk(nAlert, 1);
		chk(nLoad, 0);
		{intgGlobal, dRegionIntg} <= 2'b11;
		$display("test gating done");
	endtask : tGate

	task automatic tFetch();
		fabPulse(0, 0, 1, 0, 0, 5'h10);
		chk(nFault, 0);
		@(negedge mclk);
		nFault = 0;
		@(posedge mclk);
		iExecute <= 1'b1;
		@(posedge mclk);
		iExecute <= 1'b0;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		chk(nFault, 1);
		chk(nAlert, 2);
		chk(cause, `OBIPC_CAUSE_INSTR);
		$display("test fetch done");
	endtask : tFetch

	initial begin
		repeat (3) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		tRequest();
		tFreeze();
		tData();
		tGate();
		tFetch();
		stopTest();
	end
endmodule : obi_bus_parity_checksum_tb

// ### tb/obipc_fabric_model.sv
// Fabric side of one bus port: parity on grant and valid, response checksum.
// Assumes the bench drives the handshake and data; fault inputs stay low unless commanded.
`timescale 1ns/1ps
module obipc_fabric_model (
	// Handshake and response from the bench
	input  wire logic        gnt,
	input  wire logic        rvalid,
	input  wire logic [31:0] rdata,
	input  wire logic        err,
	// Commanded faults
	input  wire logic        badGnt,
	input  wire logic        badRv,
	input  wire logic [4:0]  badRchk,
	// Integrity towards the block
	output logic             gntPar,
	output logic             rvalidPar,
	output logic [4:0]       rchk
);
	always_comb begin
		logic [4:0] sum;
		sum       = '0;
		gntPar    = ~gnt ^ badGnt;
		rvalidPar = ~rvalid ^ badRv;
		for (int i = 0; i < 4; i++) begin
			sum[i] = ^rdata[8*i +: 8];
		end
		// Exclusive-okay is always zero, so only the error flag counts.
		sum[4] = err;
		rchk   = sum ^ badRchk;
	end
endmodule : obipc_fabric_model
